/* File: rtl/odiv_top.sv */
`timescale 1ns/100ps
module odiv_top
   import odiv_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   // axi4-lite write response
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   // axi4-lite read data
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // clock sources and chip sync pins
   input  wire logic              internal_oscillator,
   input  wire logic              clk_in,
   input  wire logic              sync_n,
   // output pairs
   output      logic              pair_a_first_output,
   output      logic              pair_a_second_output,
   output      logic              pair_b_first_output,
   output      logic              pair_b_second_output,
   // duty correction status per pair
   output      logic [1:0]        duty_correct_active
);

   // the index must fit the address above the byte lanes
   if (ADDR_W < IDX_W + 2)
   begin : g_bad_addr_w
      $error("odiv_top: ADDR_W too small for register map");
   end

   // register file
   odiv_cnt_s     cnt_r   [2];
   odiv_ctl_s     ctl_r   [2];
   odiv_route_s   route_r [2];
   logic [1:0]    src_sel;

   // divider state
   logic [1:0]    dout;
   logic [1:0]    pair_lvl;
   logic [2:0]    sync_s1;
   logic [2:0]    sync_s2;

   // bus state
   logic          aw_hold;
   logic          w_hold;
   logic [9:0]    aw_idx;
   logic [7:0]    w_byte;
   logic          w_lane0;
   logic          wr_fire;
   logic          wr_ok;
   logic [9:0]    ar_idx;
   logic [31:0]   next_rdata;
   logic          next_rerr;

   // synchronisers for the asynchronous pins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_s1 <= 3'h7;
         sync_s2 <= 3'h7;
      end
      else
      begin
         sync_s1 <= {sync_n, clk_in, internal_oscillator};
         sync_s2 <= sync_s1;
      end
   end

   // synchronised source and sync levels
   logic osc_s;
   logic clk_s;
   logic sync_act;
   logic src_lvl;
   logic direct_ok;

   assign osc_s    = sync_s2[0];
   assign clk_s    = sync_s2[1];
   assign sync_act = ~sync_s2[2];
   // direct and bypass level follows the global select; 01b keeps the clock input
   assign src_lvl  = (src_sel == SRC_OSC) ? osc_s : clk_s;
   // direct routing is void while the select reads 01b
   assign direct_ok = (src_sel != SRC_NONE);

   // write channel capture; address and data may come in either order
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
   assign wr_fire       = aw_hold & w_hold & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         aw_idx  <= 10'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_hold <= 1'b1;
         aw_idx  <= s_axi_awaddr[IDX_W+1:2];
      end
      else if (wr_fire)
      begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_hold  <= 1'b1;
         w_byte  <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
      end
      else if (wr_fire)
      begin
         w_hold <= 1'b0;
      end
   end

   // mapped write addresses; status is read only but answers okay
   always_comb
   begin
      unique case (aw_idx)
         IDX_DIV0_CNT, IDX_DIV0_CTL, IDX_DIV0_ROUTE,
         IDX_DIV1_CNT, IDX_DIV1_CTL, IDX_DIV1_ROUTE,
         IDX_SRC_SEL, IDX_STATUS: wr_ok = 1'b1;
         default:                 wr_ok = 1'b0;
      endcase
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // global source select, shared by both dividers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         src_sel <= RST_SRC_SEL;
      else if (wr_fire && w_lane0 && aw_idx == IDX_SRC_SEL)
         src_sel <= w_byte[1:0];
   end

   // per divider: registers, counter, output selection
   for (genvar i = 0; i < 2; i++)
   begin : g_div
      localparam logic [9:0] I_CNT   = i ? IDX_DIV1_CNT : IDX_DIV0_CNT;
      localparam logic [9:0] I_CTL   = i ? IDX_DIV1_CTL : IDX_DIV0_CTL;
      localparam logic [9:0] I_ROUTE = i ? IDX_DIV1_ROUTE
                                         : IDX_DIV0_ROUTE;
      localparam logic [7:0] R_CNT   = i ? RST_DIV1_CNT : RST_DIV0_CNT;
      localparam logic [7:0] R_CTL   = i ? RST_DIV1_CTL : RST_DIV0_CTL;

      logic       armed;
      logic       hold;
      logic [4:0] cnt;
      logic       direct_eff;
      logic       lvl;

      // software registers, written from byte lane 0 only
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            cnt_r[i]   <= R_CNT;
            ctl_r[i]   <= R_CTL;
            route_r[i] <= RST_ROUTE;
         end
         else if (wr_fire && w_lane0)
         begin
            if (aw_idx == I_CNT)
               cnt_r[i] <= w_byte;
            if (aw_idx == I_CTL)
               ctl_r[i] <= w_byte;
            if (aw_idx == I_ROUTE)
               route_r[i] <= w_byte[1:0];
         end
      end

      // restart after reset, on obeyed sync, and while bypassed
      assign hold = armed | ctl_r[i].bypass
                  | (sync_act & ~ctl_r[i].nosync);

      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            armed <= 1'b1;
         else
            armed <= 1'b0;
      end

      // phase counter; first phase carries the offset on top
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            dout[i] <= 1'b0;
            cnt     <= 5'h00;
         end
         else if (hold)
         begin
            dout[i] <= ctl_r[i].start_high;
            cnt     <= {1'b0, ctl_r[i].phase}
                     + {1'b0, ctl_r[i].start_high ? cnt_r[i].high
                                                  : cnt_r[i].low};
         end
         else if (cnt == 5'h00)
         begin
            // ratio is (low+1)+(high+1), 2..32 cycles
            dout[i] <= ~dout[i];
            cnt     <= {1'b0, dout[i] ? cnt_r[i].low
                                      : cnt_r[i].high};
         end
         else
         begin
            cnt <= cnt - 5'h01;
         end
      end

      // output choice: direct route, bypass, forced level, divided
      assign direct_eff = route_r[i].direct & direct_ok;

      always_comb
      begin
         if (direct_eff)
            lvl = src_lvl;
         else if (ctl_r[i].bypass)
            lvl = src_lvl;
         else if (ctl_r[i].nosync && ctl_r[i].force_high)
            lvl = 1'b1;
         else
            lvl = dout[i];
      end

      // registered so the pair leaves glitch free
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            pair_lvl[i] <= 1'b0;
         else
            pair_lvl[i] <= lvl;
      end

      // correction acts on the undivided path only
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
            duty_correct_active[i] <= 1'b0;
         else
            duty_correct_active[i] <=
               ~route_r[i].duty_correction_disable
               & (direct_eff | ctl_r[i].bypass);
      end
   end

   // differential style pair outputs
   assign pair_a_first_output  = pair_lvl[0];
   assign pair_a_second_output = ~pair_lvl[0];
   assign pair_b_first_output  = pair_lvl[1];
   assign pair_b_second_output = ~pair_lvl[1];

   // read address decode
   assign ar_idx        = s_axi_araddr[IDX_W+1:2];
   assign s_axi_arready = ~s_axi_rvalid;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_rerr  = 1'b0;
      unique case (ar_idx)
         IDX_DIV0_CNT:   next_rdata[7:0] = cnt_r[0];
         IDX_DIV0_CTL:   next_rdata[7:0] = ctl_r[0];
         IDX_DIV0_ROUTE: next_rdata[1:0] = route_r[0];
         IDX_DIV1_CNT:   next_rdata[7:0] = cnt_r[1];
         IDX_DIV1_CTL:   next_rdata[7:0] = ctl_r[1];
         IDX_DIV1_ROUTE: next_rdata[1:0] = route_r[1];
         IDX_SRC_SEL:    next_rdata[1:0] = src_sel;
         IDX_STATUS:     next_rdata[4:0] = {sync_act,
                                            duty_correct_active,
                                            dout};
         default:        next_rerr = 1'b1;
      endcase
   end

   // read data one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : odiv_top

/* File: rtl/odiv_pkg.sv */
package odiv_pkg;

   // register indices; byte address is four times the index
   localparam int          IDX_W          = 10;
   localparam logic [9:0]  IDX_DIV0_CNT   = 10'h190;
   localparam logic [9:0]  IDX_DIV0_CTL   = 10'h191;
   localparam logic [9:0]  IDX_DIV0_ROUTE = 10'h192;
   localparam logic [9:0]  IDX_DIV1_CNT   = 10'h193;
   localparam logic [9:0]  IDX_DIV1_CTL   = 10'h194;
   localparam logic [9:0]  IDX_DIV1_ROUTE = 10'h195;
   localparam logic [9:0]  IDX_SRC_SEL    = 10'h1E1;
   localparam logic [9:0]  IDX_STATUS     = 10'h1E2;

   // reset values per divider, then the shared route and source select resets
   localparam logic [7:0]  RST_DIV0_CNT   = 8'h00;
   localparam logic [7:0]  RST_DIV1_CNT   = 8'hBB;
   localparam logic [7:0]  RST_DIV0_CTL   = 8'h80;
   localparam logic [7:0]  RST_DIV1_CTL   = 8'h00;
   localparam logic [1:0]  RST_ROUTE      = 2'h0;
   localparam logic [1:0]  RST_SRC_SEL    = 2'h0;

   // global source select codes
   localparam logic [1:0]  SRC_CLK        = 2'h0;
   localparam logic [1:0]  SRC_NONE       = 2'h1;
   localparam logic [1:0]  SRC_OSC        = 2'h2;

   // bus responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // phase counts: low in [7:4], high in [3:0]
   typedef struct packed {
      logic [3:0] low;
      logic [3:0] high;
   } odiv_cnt_s;

   // control: bypass 7, nosync 6, force 5, start 4, phase [3:0]
   typedef struct packed {
      logic       bypass;
      logic       nosync;
      logic       force_high;
      logic       start_high;
      logic [3:0] phase;
   } odiv_ctl_s;

   // routing: direct 1, duty correction disable 0
   typedef struct packed {
      logic direct;
      logic duty_correction_disable;
   } odiv_route_s;

endpackage : odiv_pkg

/* File: bench/odiv_props.sv */
`timescale 1ns/100ps
module odiv_props
   import odiv_pkg::*;
(
   // watched top ports
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        pair_a_first_output,
   input wire logic        pair_a_second_output,
   input wire logic        pair_b_first_output,
   input wire logic        pair_b_second_output
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // a read answers on the next cycle, a write within one or two cycles
   property p_wr;
      s_wr |-> ##[1:2] s_axi_bvalid;
   endproperty
   property p_rd;
      s_rd |=> s_axi_rvalid;
   endproperty
   // answers stand until the master takes them
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   // no second request while an answer is pending
   property p_arref;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_wref;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   // unmapped reads return zero data
   property p_rsp;
      s_axi_rvalid |-> s_axi_rresp == RESP_OKAY
         || s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
   endproperty
   // each pair is a true complement
   property p_pairs;
      pair_a_second_output == !pair_a_first_output
         && pair_b_second_output == !pair_b_first_output;
   endproperty
   a_wr: assert property (p_wr) else $error("write unanswered");
   a_rd: assert property (p_rd) else $error("read unanswered");
   a_bhold: assert property (p_bhold) else $error("bresp dropped");
   a_rhold: assert property (p_rhold) else $error("rdata dropped");
   a_arref: assert property (p_arref) else $error("arready early");
   a_wref: assert property (p_wref) else $error("awready early");
   a_rsp: assert property (p_rsp) else $error("bad read reply");
   a_pairs: assert property (p_pairs) else $error("pair skew");
endmodule : odiv_props

bind odiv_top odiv_props i_props (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .pair_a_first_output, .pair_a_second_output, .pair_b_first_output,
   .pair_b_second_output);

/* File: bench/odiv_top_test.sv */
`timescale 1ns/100ps
module odiv_top_test;
   import odiv_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, clk_in, sync_n;
   logic        internal_oscillator, pair_a_first_output;
   logic        pair_b_first_output, hs, hw, rs;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, duty_correct_active, resp;
   logic [7:0]  v;
   logic [9:0]  ri [7] = '{IDX_DIV0_CNT, IDX_DIV0_CTL, IDX_DIV0_ROUTE,
      IDX_DIV1_CNT, IDX_DIV1_CTL, IDX_DIV1_ROUTE, IDX_SRC_SEL};
   logic [7:0]  rv [7] = '{8'h00, 8'h80, 8'h00, 8'hBB, 8'h00, 8'h00, 8'h00};
   int          dh [3] = '{4, 4, 3};
   int          dl [3] = '{4, 3, 3};
   int          failures, checks, n, tc, c, c0;

   odiv_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .internal_oscillator,
      .clk_in, .sync_n, .pair_a_first_output, .pair_a_second_output(),
      .pair_b_first_output, .pair_b_second_output(),
      .duty_correct_active);

   // 10 MHz clock
   initial
   begin
      aclk = 0;
      forever #50 aclk = ~aclk;
   end

   // slow sources: clock input 4/4, oscillator 3/3, both synced inside
   always @(posedge aclk)
   begin
      tc <= tc + 1;
      if (tc % 4 == 3)
         clk_in <= ~clk_in;
      if (tc % 3 == 2)
         internal_oscillator <= ~internal_oscillator;
   end

   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : cmp

   // one bus transfer; handshakes judged at negedge where all is settled
   task automatic xf(bit wr, logic [9:0] ix, logic [7:0] d,
                     logic [1:0] er, logic [31:0] ed);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr} <= {ix, 2'b00, ix, 2'b00};
      s_axi_wdata <= {24'h0, d};
      // ready is raised only once the answer shows, so it must stand
      {s_axi_awvalid, s_axi_wvalid} <= {2{wr}};
      s_axi_arvalid <= !wr;
      for (n = 0; n < 50; n++)
      begin
         @(negedge aclk);
         hs = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
         hw = s_axi_wready & s_axi_wvalid;
         rs = wr ? s_axi_bvalid : s_axi_rvalid;
         resp = wr ? s_axi_bresp : s_axi_rresp;
         rd = s_axi_rdata;
         @(posedge aclk);
         if (hs)
            {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
         if (hw)
            s_axi_wvalid <= 0;
         if (rs && (s_axi_bready || s_axi_rready))
            break;
         if (rs)
            {s_axi_bready, s_axi_rready} <= {wr, !wr};
      end
      {s_axi_bready, s_axi_rready} <= 2'b00;
      cmp("wait", 0, n == 50);
      if (n == 50)
         complete_run();
      cmp("resp", er, resp);
      if (!wr)
         cmp("rdata", ed, rd);
   endtask : xf

   // counts negedges while the output keeps level lv
   task automatic run(bit pb, logic lv, output int k);
      for (k = 0; k < 100; k++)
      begin
         @(negedge aclk);
         if ((pb ? pair_b_first_output : pair_a_first_output) !== lv)
            break;
      end
   endtask : run

   // skips a partial period, then times one high and one low phase
   task automatic per(bit pb, int eh, int el);
      int h, l;
      run(pb, 1, c);
      run(pb, 0, c);
      run(pb, 1, h);
      run(pb, 0, l);
      cmp("high", eh, h + 1);
      cmp("low", el, l + 1);
   endtask : per

   // length of the first phase after a sync restart
   function automatic int first(logic [7:0] ct, logic [7:0] cn);
      return ct[3:0] + (ct[4] ? cn[3:0] : cn[7:4]) + 1;
   endfunction : first

   task automatic complete_run;
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, clk_in, internal_oscillator} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {failures, checks, tc} = '0;
      s_axi_wstrb = 4'hf;
      sync_n = 1;
      void'($urandom(32'h0f323f0a));
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      foreach (ri[i])
         xf(0, ri[i], 0, RESP_OKAY, rv[i]);
      xf(0, 10'h3FF, 0, RESP_SLVERR, 0);
      xf(1, 10'h3FF, 8'h55, RESP_SLVERR, 0);
      per(1, 12, 12);
      per(0, 4, 4);
      cmp("dca", 2'b01, duty_correct_active);
      xf(1, IDX_DIV0_ROUTE, 8'h01, RESP_OKAY, 0);
      repeat (3) @(negedge aclk);
      cmp("dca", 2'b00, duty_correct_active);
      // both extreme ratios, then random counts on alternate dividers
      for (int i = 0; i < 6; i++)
      begin
         v = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom);
         xf(1, i[0] ? IDX_DIV1_CNT : IDX_DIV0_CNT, v, RESP_OKAY, 0);
         xf(1, i[0] ? IDX_DIV1_CTL : IDX_DIV0_CTL, 0, RESP_OKAY, 0);
         per(i[0], v[3:0] + 1, v[7:4] + 1);
      end
      // force needs sync ignored and never beats bypass
      xf(1, IDX_DIV1_CNT, 8'h23, RESP_OKAY, 0);
      xf(1, IDX_DIV1_CTL, 8'h20, RESP_OKAY, 0);
      per(1, 4, 3);
      xf(1, IDX_DIV1_CTL, 8'hE0, RESP_OKAY, 0);
      per(1, 4, 4);
      xf(1, IDX_DIV1_CTL, 8'h60, RESP_OKAY, 0);
      repeat (3) @(negedge aclk);
      run(1, 1, c);
      cmp("forced", 100, c);
      // sync held: a divider that ignores it keeps toggling
      xf(1, IDX_DIV1_CTL, 8'h40, RESP_OKAY, 0);
      sync_n <= 0;
      repeat (4) @(negedge aclk);
      per(1, 4, 3);
      // start level and first-phase length after each sync release
      for (int j = 0; j < 3; j++)
      begin
         v = j == 2 ? 8'h09 : j == 1 ? 8'h15 : 8'h10;
         xf(1, IDX_DIV1_CTL, v, RESP_OKAY, 0);
         sync_n <= 0;
         repeat (6) @(negedge aclk);
         cmp("start", j != 2, pair_b_first_output);
         @(posedge aclk);
         sync_n <= 1;
         run(1, j != 2, c);
         if (j == 0)
            c0 = c;
         else
            cmp("first", first(v, 8'h23) - 4, c - c0);
      end
      // direct routing under every source select code
      for (int p = 0; p < 2; p++)
      begin
         xf(1, p ? IDX_DIV1_CNT : IDX_DIV0_CNT, 8'h23, RESP_OKAY, 0);
         xf(1, p ? IDX_DIV1_CTL : IDX_DIV0_CTL, 0, RESP_OKAY, 0);
         xf(1, p ? IDX_DIV1_ROUTE : IDX_DIV0_ROUTE, 2, RESP_OKAY, 0);
         for (int s = 0; s < 3; s++)
         begin
            xf(1, IDX_SRC_SEL, 8'(s), RESP_OKAY, 0);
            per(p[0], dh[s], dl[s]);
         end
      end
      complete_run();
   end
endmodule : odiv_top_test
